// [inc/evt_timer_pkg.sv]
package evt_timer_pkg;
  // Timer population and widths.
  localparam int NUM_TIMERS = 8;
  localparam int FAST_W = 64;
  localparam int SLOW_W = 82;
  localparam int FRAC_W = 18;
  localparam int CALIB_W = 28;
  localparam int HALF_W = 32;
  localparam int ROUTE_W = 5;
  localparam int IRQ_LINES = 1 << ROUTE_W;
  // Software-visible placement of the overall enable bit.
  localparam logic [7:0] CFG_REG_OFFSET = 8'h10;
  localparam int ENABLE_BIT_POS = 0;
  // Clock rates and the worst-case mode switch delay.
  localparam int REF_CLK_MHZ = 100;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int SWITCH_MAX_US = 30;
  localparam int SWITCH_MAX_CYC = SWITCH_MAX_US * REF_CLK_MHZ;
  // Reset values and capability constants.
  localparam logic [FAST_W-1:0] COUNT_RESET = 64'h0;
  localparam logic [FAST_W-1:0] COUNT_STEP = 64'h1;
  localparam logic [SLOW_W-1:0] SLOW_RESET = 82'h0;
  localparam logic [FAST_W-1:0] CMP_RESET = 64'h0000_0000_FFFF_FFFF;
  localparam logic [FAST_W-1:0] PERIOD_RESET = 64'h0;
  localparam logic [NUM_TIMERS-1:0] PERIODIC_CAP = 8'h01;
  localparam logic [NUM_TIMERS-1:0] WIDE_CAP = 8'h01;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // Off-load sequencing states.
  typedef enum logic [1:0] {
    ST_FAST,
    ST_ARMED,
    ST_PARKED,
    ST_SLOW
  } offload_state_t;
endpackage : evt_timer_pkg

// [core/timer_comparator.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_comparator
  import evt_timer_pkg::*;
#(
  parameter bit PERIODIC_OK = 1'b0,
  parameter bit WIDE_OK = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [FAST_W-1:0] count,
  input wire logic tick,
  input wire logic enable,
  input wire logic wide_mode,
  input wire logic periodic_mode,
  input wire logic int_en,
  input wire logic level_mode,
  input wire logic wr_en,
  input wire logic wr_upper,
  input wire logic direct_write,
  input wire logic [HALF_W-1:0] wr_data,
  input wire logic sts_clr,
  output logic [FAST_W-1:0] cmp_value,
  output logic sts,
  output logic irq
);
  typedef struct packed {
    logic [FAST_W-1:0] cmp;
    logic [FAST_W-1:0] period;
    logic sts;
    logic irq;
  } cmp_state_t;
  cmp_state_t s_q, s_d;
  logic wide;
  logic periodic;
  logic match;
  logic load;

  // Capability straps mask modes this timer cannot run.
  assign wide = WIDE_OK & wide_mode;
  assign periodic = PERIODIC_OK & periodic_mode;
  assign load = ~periodic | direct_write;
  assign match = enable & tick & (wide ? (count == s_q.cmp)
               : (count[HALF_W-1:0] == s_q.cmp[HALF_W-1:0]));

  // Next comparator, period, status and interrupt state.
  always_comb begin
    s_d = s_q;
    if (match && periodic) begin
      if (wide) begin
        s_d.cmp = s_q.cmp + s_q.period;
      end else begin
        s_d.cmp[HALF_W-1:0] = s_q.cmp[HALF_W-1:0] + s_q.period[HALF_W-1:0];
      end
    end
    if (wr_en && wr_upper && WIDE_OK) begin
      s_d.period[FAST_W-1:HALF_W] = wr_data;
      if (load) begin
        s_d.cmp[FAST_W-1:HALF_W] = wr_data;
      end
    end else if (wr_en && !wr_upper) begin
      s_d.period[HALF_W-1:0] = wr_data;
      if (load) begin
        s_d.cmp[HALF_W-1:0] = wr_data;
      end
    end
    if (sts_clr) begin
      s_d.sts = 1'b0;
    end
    if (match && int_en) begin
      s_d.sts = 1'b1;
    end
    s_d.irq = int_en & (level_mode ? s_d.sts : match);
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '{cmp: CMP_RESET, period: PERIOD_RESET, sts: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cmp_value = s_q.cmp;
  assign sts = s_q.sts;
  assign irq = s_q.irq;

  a_oneshot_stable: assert property (@(posedge ref_clk) disable iff (reset)
    (!periodic && !wr_en) |=> $stable(s_q.cmp))
    else $error("one-shot comparator changed without a write");
  a_periodic_add: assert property (@(posedge ref_clk) disable iff (reset)
    (match && periodic && wide && !wr_en) |=> (s_q.cmp == $past(s_q.cmp) + $past(s_q.period)))
    else $error("periodic comparator not advanced by period");
  a_periodic_narrow: assert property (@(posedge ref_clk) disable iff (reset)
    (match && periodic && !wide && !wr_en)
    |=> (s_q.cmp[HALF_W-1:0] == $past(s_q.cmp[HALF_W-1:0]) + $past(s_q.period[HALF_W-1:0])))
    else $error("narrow periodic comparator not advanced by period");
  a_level_irq: assert property (@(posedge ref_clk) disable iff (reset)
    (match && int_en && level_mode) |=> (irq && sts))
    else $error("level interrupt missing after match");
endmodule : timer_comparator
`default_nettype wire

// [core/event_timer_offload.sv]
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Eight timers share one counter, each with own comparator.
// - Each timer interrupts when comparator equals counter.
// - Counter only increases unless it wraps.
// - Enabled fast counter adds one every clock.
// - Stopped crystal: count on the 32.768 kHz clock.
// - Off-load refused while any comparator is active.
// - Controller holds off-load request; device returns slow-mode flag.
// - Slow counter adds 28-bit calibration each slow rising edge.
// - Mode switches only on slow rising edges.
// - Entry puts fast count in upper 64 bits.
// - Synchronised slow edge parks count; next edge adds increment.
// - Exit on slow edge loads upper bits and drops flag on the same clock.
// - Reload keeps the 18 fractional bits.
// - Early exit does both transitions on one slow edge.
// - One-shot comparator never changed by hardware.
// - Periodic match adds period; readback gives next match.
// - Periodic comparator write sets the next increment.
// - Value-set bit makes each half write a direct load.
// - Timer 0 is 32 or 64 bits; others 32.
// - Only timer 0 periodic; capability bits report it.
// - Overall enable gates counting, except the slow add on the first edge after park, and match interrupts.
// - Per-timer routing and edge or level type.
module event_timer_offload
  import evt_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic overall_enable_bit,
  input wire logic slow_clk,
  input wire logic offload_req,
  input wire logic [CALIB_W-1:0] calib_incr,
  input wire logic cnt_wr_en,
  input wire logic [FAST_W-1:0] cnt_wr_data,
  input wire logic timer0_wide,
  input wire logic timer0_periodic,
  input wire logic [NUM_TIMERS-1:0] tmr_int_en,
  input wire logic [NUM_TIMERS-1:0] tmr_level_mode,
  input wire logic [NUM_TIMERS*ROUTE_W-1:0] per_timer_irq_route,
  input wire logic [NUM_TIMERS-1:0] per_timer_direct_value_write,
  input wire logic [NUM_TIMERS-1:0] cmp_wr_en,
  input wire logic cmp_wr_upper,
  input wire logic [HALF_W-1:0] cmp_wr_data,
  input wire logic [NUM_TIMERS-1:0] tmr_sts_clr,
  input wire logic [2:0] cmp_rd_sel,
  output logic [FAST_W-1:0] main_count,
  output logic slow_mode_active,
  output logic offload_refused,
  output logic [NUM_TIMERS-1:0] tmr_int_sts,
  output logic [IRQ_LINES-1:0] irq_line,
  output logic [FAST_W-1:0] cmp_rd_data,
  output logic [NUM_TIMERS-1:0] periodic_capable
);

  ////////////////////////////////////////////////////////////////////
  // State record.
  typedef struct packed {
    logic [FAST_W-1:0] count;
    logic [SLOW_W-1:0] slow;
    offload_state_t st;
    logic [2:0] sync;
    logic active;
    logic refused;
    logic tick;
    logic [IRQ_LINES-1:0] irq;
    logic [FAST_W-1:0] rd;
    logic [NUM_TIMERS-1:0] cap;
  } top_state_t;

  top_state_t s_q, s_d;
  logic slow_edge;
  logic any_active;
  logic [SLOW_W-1:0] slow_sum;
  logic [FAST_W-1:0] cmp_val [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tmr_irq;
  logic [NUM_TIMERS-1:0] tmr_sts;
  logic [NUM_TIMERS-1:0] wide_sel;
  logic [NUM_TIMERS-1:0] per_sel;

  ////////////////////////////////////////////////////////////////////
  // Shared helpers.

  // Rising edge of the slow clock seen after the two sync stages.
  // synchronised slow edge
  assign slow_edge = s_q.sync[1] & ~s_q.sync[2];

  // A comparator counts as active while its interrupt and the overall enable are both set.
  assign any_active = overall_enable_bit & (|tmr_int_en);

  // Calibrated slow step, the increment widened to the slow counter.
  // calibrated slow add
  assign slow_sum = s_q.slow + SLOW_W'(calib_incr);

  // Mode selects reach only timer 0; others stay 32-bit one-shot.
  // width only timer 0
  assign wide_sel = WIDE_CAP & {NUM_TIMERS{timer0_wide}};
  assign per_sel = PERIODIC_CAP & {NUM_TIMERS{timer0_periodic}};

  ////////////////////////////////////////////////////////////////////
  // Comparators, one per timer.
  // one comparator per timer
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    timer_comparator #(
      .PERIODIC_OK(PERIODIC_CAP[i]),
      .WIDE_OK(WIDE_CAP[i])
    ) u_cmp (
      .ref_clk(ref_clk),
      .reset(reset),
      .count(s_q.count),
      .tick(s_q.tick),
      .enable(overall_enable_bit),
      .wide_mode(wide_sel[i]),
      .periodic_mode(per_sel[i]),
      .int_en(tmr_int_en[i]),
      .level_mode(tmr_level_mode[i]),
      .wr_en(cmp_wr_en[i]),
      .wr_upper(cmp_wr_upper),
      .direct_write(per_timer_direct_value_write[i]),
      .wr_data(cmp_wr_data),
      .sts_clr(tmr_sts_clr[i]),
      .cmp_value(cmp_val[i]),
      .sts(tmr_sts[i]),
      .irq(tmr_irq[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Next-state logic for counter, off-load sequencer and outputs.
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // The first stage feeds only the second; edges use the second and third stages.
    s_d.sync = {s_q.sync[1:0], slow_clk};
    s_d.refused = 1'b0;
    case (s_q.st)
      ST_FAST: begin
        if (cnt_wr_en) begin
          s_d.count = cnt_wr_data;
        end else if (overall_enable_bit) begin
          s_d.count = s_q.count + COUNT_STEP;
          s_d.tick = 1'b1;
        end
        if (offload_req && any_active) begin
          s_d.refused = 1'b1;
        end else if (offload_req) begin
          s_d.st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // The count keeps running until the park edge arrives.
        if (cnt_wr_en) begin
          s_d.count = cnt_wr_data;
        end else if (overall_enable_bit) begin
          s_d.count = s_q.count + COUNT_STEP;
          s_d.tick = 1'b1;
        end
        if (!offload_req || any_active) begin
          s_d.refused = offload_req;
          s_d.st = ST_FAST;
        end else if (slow_edge) begin
          s_d.slow[SLOW_W-1:FRAC_W] = s_q.count;
          // Freeze the count on the park edge so it equals the parked copy.
          s_d.count = s_q.count;
          s_d.tick = 1'b0;
          s_d.active = 1'b1;
          s_d.st = ST_PARKED;
        end
      end
      ST_PARKED: begin
        if (slow_edge) begin
          s_d.slow = slow_sum;
          if (!offload_req) begin
            s_d.count = slow_sum[SLOW_W-1:FRAC_W];
            s_d.active = 1'b0;
            s_d.st = ST_FAST;
          end else begin
            s_d.st = ST_SLOW;
          end
        end
      end
      ST_SLOW: begin
        if (slow_edge && overall_enable_bit) begin
          s_d.slow = slow_sum;
        end
        if (slow_edge && !offload_req) begin
          s_d.count = overall_enable_bit ? slow_sum[SLOW_W-1:FRAC_W]
                    : s_q.slow[SLOW_W-1:FRAC_W];
          s_d.active = 1'b0;
          s_d.st = ST_FAST;
        end
      end
      default: begin
        s_d.st = ST_FAST;
        s_d.active = 1'b0;
      end
    endcase
    s_d.irq = '0;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (tmr_irq[t]) begin
        s_d.irq[per_timer_irq_route[t*ROUTE_W +: ROUTE_W]] = 1'b1;
      end
    end
    s_d.rd = cmp_val[cmp_rd_sel];
    s_d.cap = PERIODIC_CAP;
  end

  ////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q.count <= COUNT_RESET;
      s_q.slow <= SLOW_RESET;
      s_q.st <= ST_FAST;
      s_q.sync <= SYNC_RESET;
      s_q.active <= 1'b0;
      s_q.refused <= 1'b0;
      s_q.tick <= 1'b0;
      s_q.irq <= '0;
      s_q.rd <= CMP_RESET;
      s_q.cap <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs are taken from flip-flops.
  assign main_count = s_q.count;
  assign slow_mode_active = s_q.active;
  assign offload_refused = s_q.refused;
  assign tmr_int_sts = tmr_sts;
  assign irq_line = s_q.irq;
  assign cmp_rd_data = s_q.rd;
  assign periodic_capable = s_q.cap;

  ////////////////////////////////////////////////////////////////////
  // Checks.

  a_count_monotonic: assert property (@(posedge ref_clk) disable iff (reset)
    (!cnt_wr_en) |=> ((s_q.count >= $past(s_q.count)) || ($past(s_q.count) == '1)))
    else $error("main counter went backwards");

  a_count_step: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_FAST && overall_enable_bit && !cnt_wr_en && !offload_req)
    |=> (s_q.count == $past(s_q.count) + COUNT_STEP))
    else $error("fast counter did not step by one");

  a_count_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!overall_enable_bit && !cnt_wr_en && s_q.st != ST_SLOW && s_q.st != ST_PARKED)
    |=> $stable(s_q.count))
    else $error("counter moved while disabled");

  a_offload_refuse: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_FAST && offload_req && any_active)
    |=> (s_q.st == ST_FAST && offload_refused))
    else $error("off-load accepted with an active comparator");

  a_park_load: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_ARMED && offload_req && !any_active && slow_edge)
    |=> (s_q.slow[SLOW_W-1:FRAC_W] == $past(s_q.count)) && slow_mode_active
        && $stable(s_q.slow[FRAC_W-1:0]))
    else $error("park did not load the upper slow bits");

  a_slow_add: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_SLOW && slow_edge && overall_enable_bit)
    |=> (s_q.slow == $past(slow_sum)))
    else $error("slow counter missed the calibrated add");

  a_exit_load: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_SLOW && slow_edge && !offload_req && overall_enable_bit)
    |=> (s_q.count == $past(slow_sum[SLOW_W-1:FRAC_W])) && !slow_mode_active)
    else $error("exit did not load the slow count");

  a_switch_edge: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(slow_mode_active) |-> $past(slow_edge))
    else $error("mode changed away from a slow edge");

  a_early_exit: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_PARKED && slow_edge && !offload_req)
    |=> (s_q.st == ST_FAST) && !slow_mode_active)
    else $error("early exit took more than one slow edge");

  // Sequencer, counter, capability and routing checks.
  a_park_freeze: assert property (@(posedge ref_clk) disable iff (reset)
    ((s_q.st == ST_PARKED || s_q.st == ST_SLOW) && !(slow_edge && !offload_req))
    |=> $stable(s_q.count))
    else $error("parked count moved");

  a_slow_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (slow_mode_active && offload_req) |=> slow_mode_active)
    else $error("slow mode dropped while the request stood");

  a_parked_add: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_PARKED && slow_edge) |=> (s_q.slow == $past(slow_sum)))
    else $error("parked value missed the first calibrated add");

  a_refuse_stay: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_ARMED && any_active) |=> (s_q.st == ST_FAST))
    else $error("armed sequencer kept going with an active comparator");

  a_refused_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    offload_refused |-> ($past(offload_req) && $past(any_active)))
    else $error("refusal flagged without an active comparator");

  a_enable_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !overall_enable_bit |=> !s_q.tick)
    else $error("count ticked while disabled");

  a_wrap_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_FAST && overall_enable_bit && !cnt_wr_en && (&s_q.count))
    |=> (s_q.count == '0))
    else $error("counter did not wrap to zero");

  a_cap_report: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> (periodic_capable == PERIODIC_CAP))
    else $error("capability bits wrong");

  a_irq_route: assert property (@(posedge ref_clk) disable iff (reset)
    tmr_irq[0] |=> irq_line[$past(per_timer_irq_route[ROUTE_W-1:0])])
    else $error("timer 0 interrupt missing on its routed line");

endmodule : event_timer_offload
`default_nettype wire

// [dv/pwr_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pwr_ctrl_model
  import evt_timer_pkg::*;
#(
  parameter int HALF_NS = 15259
) (
  input wire logic idle_want,
  input wire logic [CALIB_W-1:0] calib_val,
  output logic slow_clk,
  output logic offload_req,
  output logic [CALIB_W-1:0] calib_incr
);
  // The real-time clock runs free, out of phase with the fast clock.
  // slow time base
  initial begin
    slow_clk = 1'b0;
    #7;
    forever #(HALF_NS) slow_clk = ~slow_clk;
  end
  assign offload_req = idle_want;
  assign calib_incr = calib_val;
endmodule : pwr_ctrl_model
`default_nettype wire

// [dv/event_timer_offload_test.sv]
`timescale 1ns/1ps
`default_nettype none
module event_timer_offload_test;
  import evt_timer_pkg::*;
  logic ref_clk, reset, en, idle_want, cnt_wr_en, t0_wide, t0_per, cmp_wr_upper;
  logic slow_clk, offload_req, slow_mode_active, offload_refused;
  logic [CALIB_W-1:0] calib_val, calib_incr;
  logic [FAST_W-1:0] cnt_wr_data, main_count, cmp_rd_data;
  logic [NUM_TIMERS-1:0] int_en, lvl, direct, cmp_wr_en, sts_clr, sts, cap;
  logic [NUM_TIMERS*ROUTE_W-1:0] route;
  logic [HALF_W-1:0] cmp_wr_data;
  logic [2:0] rd_sel;
  logic [IRQ_LINES-1:0] irq_line;
  logic [SLOW_W-1:0] slow_exp;
  int fails, cmp_count;

  event_timer_offload dut (.ref_clk(ref_clk), .reset(reset), .overall_enable_bit(en),
    .slow_clk(slow_clk), .offload_req(offload_req), .calib_incr(calib_incr),
    .cnt_wr_en(cnt_wr_en), .cnt_wr_data(cnt_wr_data), .timer0_wide(t0_wide),
    .timer0_periodic(t0_per), .tmr_int_en(int_en), .tmr_level_mode(lvl),
    .per_timer_irq_route(route), .per_timer_direct_value_write(direct),
    .cmp_wr_en(cmp_wr_en), .cmp_wr_upper(cmp_wr_upper), .cmp_wr_data(cmp_wr_data),
    .tmr_sts_clr(sts_clr), .cmp_rd_sel(rd_sel), .main_count(main_count),
    .slow_mode_active(slow_mode_active), .offload_refused(offload_refused),
    .tmr_int_sts(sts), .irq_line(irq_line), .cmp_rd_data(cmp_rd_data),
    .periodic_capable(cap));
  pwr_ctrl_model pcm (.idle_want(idle_want), .calib_val(calib_val),
    .slow_clk(slow_clk), .offload_req(offload_req), .calib_incr(calib_incr));

  // The 100 MHz fast clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drivers act at the falling edge so the rising edge sees settled inputs.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic chk(input string what, input logic [FAST_W-1:0] exp,
                     input logic [FAST_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic give_up();
    fails++;
    summarize();
  endtask : give_up
  task automatic wait_sts(input int t);
    int i;
    for (i = 0; i < 300 && sts[t] !== 1'b1; i++) cyc(1);
    if (i == 300) give_up();
  endtask : wait_sts
  task automatic cnt_load(input logic [FAST_W-1:0] v);
    cnt_wr_en = 1'b1;
    cnt_wr_data = v;
    cyc(1);
    cnt_wr_en = 1'b0;
  endtask : cnt_load
  task automatic cmp_wr(input int t, input logic up, input logic dir,
                        input logic [HALF_W-1:0] d);
    direct[t] = dir;
    cmp_wr_upper = up;
    cmp_wr_data = d;
    cmp_wr_en[t] = 1'b1;
    cyc(1);
    cmp_wr_en[t] = 1'b0;
    direct[t] = 1'b0;
    cyc(1);
  endtask : cmp_wr
  task automatic rd_chk(input int t, input logic [FAST_W-1:0] exp);
    rd_sel = 3'(t);
    cyc(2);
    chk("comparator", exp, cmp_rd_data);
  endtask : rd_chk
  // One off-load; the model of the slow counter keeps its fraction between calls.
  task automatic offload(input bit early);
    int i, j, k;
    logic [FAST_W-1:0] c;
    logic prev;
    idle_want = 1'b1;
    for (i = 0; i < 4000 && slow_mode_active !== 1'b1; i++) cyc(1);
    if (i == 4000) give_up();
    c = main_count;
    slow_exp = {c, slow_exp[FRAC_W-1:0]};
    prev = slow_clk;
    j = 0;
    k = 0;
    if (early) idle_want = 1'b0;
    for (i = 0; i < 20000 && slow_mode_active === 1'b1; i++) begin
      chk("parked count", c, main_count);
      cyc(1);
      j = (slow_clk && !prev) ? 0 : j + 1;
      k += (slow_clk && !prev) ? 1 : 0;
      prev = slow_clk;
      if (k == 2 && j == 100) idle_want = 1'b0;
    end
    if (i == 20000) give_up();
    chk("slow edges", early ? 64'h1 : 64'h3, 64'(k));
    slow_exp += SLOW_W'(k) * SLOW_W'(calib_val);
    chk("exit count", slow_exp[SLOW_W-1:FRAC_W], main_count);
  endtask : offload

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int t, r;
    logic [HALF_W-1:0] v, p, q;
    logic [FAST_W-1:0] d;
    logic seen;
    reset = 1'b1;
    {en, idle_want, cnt_wr_en, t0_wide, t0_per, cmp_wr_upper} = '0;
    {int_en, lvl, direct, cmp_wr_en, sts_clr, route, rd_sel, cnt_wr_data, cmp_wr_data} = '0;
    slow_exp = '0;
    fails = 0;
    cmp_count = 0;
    void'($urandom(32'h63FFC915));
    calib_val = CALIB_W'($urandom);
    cyc(2);
    reset = 1'b0;
    cyc(1);
    chk("capability", 64'h01, 64'(cap));
    chk("comparator reset", 64'h0000_0000_FFFF_FFFF, cmp_rd_data);
    en = 1'b1;
    cyc(1);
    d = main_count;
    cyc(5);
    chk("count step", d + 64'h5, main_count);
    en = 1'b0;
    cyc(1);
    d = main_count;
    cyc(4);
    chk("count hold", d, main_count);
    en = 1'b1;
    cnt_load('1);
    cyc(1);
    chk("count wrap", '0, main_count);
    // One-shot match on a random timer, edge type then level type.
    for (int m = 0; m < 2; m++) begin
      t = 1 + $urandom % 7;
      r = $urandom % IRQ_LINES;
      route[t*ROUTE_W +: ROUTE_W] = ROUTE_W'(r);
      lvl[t] = m[0];
      int_en[t] = 1'b1;
      v = $urandom;
      cnt_load({$urandom, v});
      cmp_wr(t, 1'b0, 1'b1, v + 32'h28);
      wait_sts(t);
      chk("match point", 64'(v + 32'h29), 64'(main_count[31:0]));
      cyc(1);
      chk("irq line", 64'h1, 64'(irq_line[r]));
      cyc(1);
      chk("irq type", 64'(m[0]), 64'(irq_line[r]));
      rd_chk(t, {32'h0, v + 32'h28});
      sts_clr[t] = 1'b1;
      cyc(1);
      sts_clr[t] = 1'b0;
      cyc(2);
      chk("irq cleared", 64'h0, 64'(irq_line[r]));
    end
    idle_want = 1'b1;
    seen = 1'b0;
    repeat (4) begin
      cyc(1);
      seen |= offload_refused;
    end
    chk("refused", 64'h1, 64'(seen));
    chk("slow flag", 64'h0, 64'(slow_mode_active));
    idle_want = 1'b0;
    int_en = '0;
    // Periodic timer 0, then a new period.
    en = 1'b0;
    t0_per = 1'b1;
    int_en[0] = 1'b1;
    cnt_load('0);
    p = 30 + $urandom % 40;
    cmp_wr(0, 1'b0, 1'b1, p);
    cmp_wr(0, 1'b1, 1'b1, '0);
    en = 1'b1;
    wait_sts(0);
    sts_clr[0] = 1'b1;
    cyc(1);
    sts_clr[0] = 1'b0;
    rd_chk(0, 64'(2 * p));
    q = 25 + $urandom % 30;
    cmp_wr(0, 1'b0, 1'b0, q);
    // The second periodic step runs the comparator at full width.
    t0_wide = 1'b1;
    wait_sts(0);
    rd_chk(0, 64'(2 * p + q));
    t0_per = 1'b0;
    int_en = '0;
    // Direct halves on timer 0 wide; upper half refused on timer 1.
    en = 1'b0;
    d = {$urandom, $urandom};
    cmp_wr(0, 1'b0, 1'b1, d[31:0]);
    cmp_wr(0, 1'b1, 1'b1, d[63:32]);
    rd_chk(0, d);
    cmp_wr(1, 1'b0, 1'b1, v);
    cmp_wr(1, 1'b1, 1'b1, ~v);
    rd_chk(1, {32'h0, v});
    t0_wide = 1'b0;
    en = 1'b1;
    offload(1'b0);
    offload(1'b1);
    summarize();
  end
endmodule : event_timer_offload_test
`default_nettype wire
